// ### bench/cior_pad_model.sv
// Purpose: pad-side partner of the configurable i/o cell bank
// Assumes: requests change only just after ref_clk rising edges
// Notes:   clock pins move at most once a cycle, so each level holds
//          for at least one full ref_clk cycle

`timescale 1ns/1ps
`default_nettype none

module cior_pad_model
   import cior_pkg::*;
(
   // clock
   input  wire logic                  ref_clk,
   // requests from the bench
   input  wire logic [NUM_SRC-1:0]    srcReq,
   input  wire logic [NUM_IN-1:0]     padReq,
   // pad side of the bank
   input  wire logic [NUM_OUT-1:0]    padOut,
   output logic      [NUM_IO_CLK-1:0] ioClk,
   output logic      [NUM_GCLK-1:0]   globalClk,
   output logic      [NUM_IN-1:0]     padIn,
   output logic      [1:0]            diffPair
);
   // pins follow requests a cycle late, like a board trace with a flop
   always_ff @(posedge ref_clk)
   begin
      {globalClk, ioClk} <= srcReq;
      padIn              <= padReq;
   end

   // complementary pair, fed from output cell padOut[0], whether it is direct or registered
   assign diffPair = {~padOut[0], padOut[0]};
endmodule

`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench for the configurable i/o cell bank
// Assumes: partner model drives pads and cell clock sources
// Notes:   apb reads are noted in a queue and checked by a monitor

`timescale 1ns/1ps
`default_nettype none

module testbench
   import cior_pkg::*;
;
   logic                  ref_clk, resetn, psel, penable, pwrite;
   logic [ADDR_W-1:0]     paddr;
   logic [31:0]           pwdata, prdata;
   logic                  pready, pslverr, cellRstPin, scanTdo;
   logic [NUM_IO_CLK-1:0] ioClk;
   logic [NUM_GCLK-1:0]   globalClk;
   logic [NUM_SRC-1:0]    srcReq;
   logic [NUM_IN-1:0]     padIn, padReq, fabIn;
   logic [NUM_OUT-1:0]    fabOut, padOut;
   cior_scan_s            scanCtl;
   logic [32:0]           expQ[$];
   string                 nameQ[$];
   int                    err_total, n_checks, seed;
   logic [7:0]            d1, f, p;

   cior_top dut_u (
      .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ioClk(ioClk),
      .globalClk(globalClk), .cellRstPin(cellRstPin), .padIn(padIn),
      .fabIn(fabIn), .fabOut(fabOut), .padOut(padOut),
      .scanCtl(scanCtl), .scanTdo(scanTdo));

   cior_pad_model pad_u (
      .ref_clk(ref_clk), .srcReq(srcReq), .padReq(padReq),
      .padOut(padOut), .ioClk(ioClk), .globalClk(globalClk),
      .padIn(padIn), .diffPair());

   // 100 MHz reference clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(string nm, logic [32:0] seen, logic [32:0] ex);
      n_checks++;
      if (seen !== ex)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one apb transfer, then an idle cycle so no signal is hit twice
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // wait for the slave; only the watchdog ends a hang
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(string nm, logic [11:0] a, logic [32:0] ex);
      expQ.push_back(ex);
      nameQ.push_back(nm);
      apb(1'b0, a, 32'h00000000);
   endtask

   task automatic results;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // monitor: every completed read is matched with the oldest note
   always @(posedge ref_clk)
      if (psel && penable && pready && !pwrite)
      begin
         if (expQ.size() == 0)
            err_total++;
         else
            chk(nameQ.pop_front(), {pslverr, prdata}, expQ.pop_front());
      end

   // watchdog, far beyond the roughly 500 cycles the run needs
   initial
   begin
      tick(20000);
      err_total++;
      results();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      seed = 42;
      {resetn, psel, penable, pwrite, cellRstPin} = '0;
      {paddr, pwdata, srcReq, padReq, fabOut, scanCtl} = '0;
      tick(8);
      resetn <= 1'b1;
      tick(1);
      // reset values and an unmapped word
      rd("regen", OFS_REGEN, {25'h0, RST_REGEN});
      rd("edge", OFS_EDGE, {25'h0, RST_EDGE});
      rd("clksel", OFS_CLKSEL, {9'h0, RST_CLKSEL});
      rd("swrst", OFS_SWRST, {25'h0, RST_SWRST});
      rd("unmapped", 12'h014, 33'h100000000);
      // direct cells follow their inputs with no storage
      repeat (4)
      begin
         d1 = 8'($random(seed));
         padReq <= d1[3:0];
         fabOut <= d1[7:4];
         tick(2);
         chk("direct", {25'h0, padOut, fabIn}, {25'h0, d1});
         rd("status", OFS_STATUS, {17'h0, d1, 8'h00});
      end
      // registered cells: every source code and both edge polarities
      apb(1'b1, OFS_REGEN, 32'h000000FF);
      for (int s = 0; s < 8; s++)
         for (int e = 0; e < 2; e++)
         begin
            d1 = 8'($random(seed));
            p = (s < NUM_SRC) ? d1 : 8'h00;
            srcReq <= {NUM_SRC{e[0]}};
            padReq <= d1[3:0];
            fabOut <= d1[7:4];
            cellRstPin <= 1'b1;
            #1 chk("reset mask", {25'h0, padOut, fabIn}, 33'h0);
            tick(1);
            // reset stays on while pins and config move, so no stray
            // transition reaches the flop before the held-zero read
            apb(1'b1, OFS_EDGE, {24'h0, {8{e[0]}}});
            apb(1'b1, OFS_CLKSEL, {8'h0, {8{s[2:0]}}});
            cellRstPin <= 1'b0;
            rd("held zero", OFS_STATUS, 33'h0);
            if (s < NUM_SRC)
               srcReq[s] <= ~e[0];
            tick(3);
            rd("capture", OFS_STATUS, {17'h0, p, p});
            padReq <= ~d1[3:0];
            fabOut <= ~d1[7:4];
            tick(3);
            if (s < NUM_SRC)
               srcReq[s] <= e[0];
            tick(3);
            rd("other edge", OFS_STATUS, {17'h0, p, p});
         end
      // software reset clears the lower cells at once, others keep data
      apb(1'b1, OFS_CLKSEL, 32'h00000000);
      srcReq[0] <= 1'b0;
      tick(3);
      apb(1'b1, OFS_SWRST, 32'h0000000F);
      p = {~d1[7:4], 4'h0};
      rd("swrst mask", OFS_STATUS, {17'h0, p, p});
      rd("swrst", OFS_SWRST, 33'h00000000F);
      // boundary scan: capture, shift a pattern through, update
      apb(1'b1, OFS_REGEN, 32'h00000000);
      f = 8'($random(seed));
      p = 8'($random(seed));
      padReq <= f[3:0];
      fabOut <= f[7:4];
      tick(2);
      scanCtl <= 5'h08;
      for (int k = 0; k < 8; k++)
      begin
         tick(1);
         scanCtl <= {4'h2, p[7-k]};
         #1 chk("scan out", {32'h0, scanTdo}, {32'h0, f[7-k]});
      end
      tick(1);
      scanCtl <= 5'h02;
      #1 chk("scan last", {32'h0, scanTdo}, {32'h0, p[7]});
      tick(1);
      scanCtl <= 5'h10;
      tick(2);
      chk("scan drive", {25'h0, padOut, fabIn}, {25'h0, p});
      // capture straight into update, pins then show the captured functional data
      scanCtl <= 5'h18;
      tick(1);
      scanCtl <= 5'h12;
      tick(2);
      chk("scan recapture", {25'h0, padOut, fabIn}, {25'h0, f});
      tick(2);
      results();
   end
endmodule

`default_nettype wire

// ### core/cior_bscan.sv
// Purpose: boundary-scan capture and update stage, one per cell
// Assumes: capture and update are synchronous one-cycle pulses on ref_clk, shift is a level
// Notes:   capture wins over shift when both are asserted

`timescale 1ns/1ps
`default_nettype none

module cior_bscan
   import cior_pkg::*;
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   // scan control
   input  wire cior_scan_s           scanCtl,
   // cell values
   input  wire logic [NUM_CELL-1:0]  funcVal,
   output logic      [NUM_CELL-1:0]  testVal,
   // serial out
   output logic                      scanTdo
);

   logic [NUM_CELL-1:0] shiftReg_q;
   logic [NUM_CELL-1:0] chainIn;

   // serial chain runs from cell 0 towards the last cell
   assign chainIn = {shiftReg_q[NUM_CELL-2:0], scanCtl.tdi};
   assign scanTdo = shiftReg_q[NUM_CELL-1];

   // ------------------------------------------------------------
   // per-cell capture and update flops
   // ------------------------------------------------------------
   for (genvar i = 0; i < NUM_CELL; i++)
   begin : g_cell
      // capture or shift stage
      always_ff @(posedge ref_clk)
      begin
         if (!resetn)
            shiftReg_q[i] <= 1'b0;
         else if (scanCtl.capture)
            shiftReg_q[i] <= funcVal[i];
         else if (scanCtl.shift)
            shiftReg_q[i] <= chainIn[i];
      end

      // update stage holds steady while the chain shifts
      always_ff @(posedge ref_clk)
      begin
         if (!resetn)
            testVal[i] <= 1'b0;
         else if (scanCtl.update)
            testVal[i] <= shiftReg_q[i];
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_scan_path;
      @(posedge ref_clk) disable iff (!resetn)
      (scanCtl.shift && !scanCtl.capture) |=>
         (shiftReg_q[0] == $past(scanCtl.tdi)) &&
         (shiftReg_q[NUM_CELL-1:1] == $past(shiftReg_q[NUM_CELL-2:0]));
   endproperty
   a_scan_path: assert property (p_scan_path)
      else $error("scan shift did not advance chain");

   property p_scan_capupd;
      @(posedge ref_clk) disable iff (!resetn)
      (scanCtl.capture ##1 (scanCtl.update && !scanCtl.capture
                            && !scanCtl.shift))
         |=> (testVal == $past(funcVal, 2));
   endproperty
   a_scan_capupd: assert property (p_scan_capupd)
      else $error("captured value not presented by update");

   c_scan_shift: cover property (@(posedge ref_clk) disable iff (!resetn)
      scanCtl.capture ##1 scanCtl.shift [*3] ##1 scanCtl.update);

endmodule

`default_nettype wire

// ### core/cior_pkg.sv
// Purpose: shared constants and types for the configurable I/O cell block
// Assumes: APB slave with 32-bit data, single reference clock
// Notes:   cells 0..3 face the pads as inputs, cells 4..7 as outputs

package cior_pkg;

   // ------------------------------------------------------------
   // cell counts and clock sources
   // ------------------------------------------------------------
   localparam int NUM_IN     = 4;
   localparam int NUM_OUT    = 4;
   localparam int NUM_CELL   = NUM_IN + NUM_OUT;
   localparam int NUM_IO_CLK = 4;   // dedicated I/O clock pins
   localparam int NUM_GCLK   = 2;   // device-wide global clocks
   localparam int NUM_SRC    = NUM_IO_CLK + NUM_GCLK;
   localparam int SEL_W      = 3;
   localparam int SRC_X      = 1 << SEL_W;  // source vector padded to 8

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam int          ADDR_W     = 12;
   localparam logic [11:0] OFS_REGEN  = 12'h000;  // 1 = registered cell
   localparam logic [11:0] OFS_EDGE   = 12'h004;  // 1 = falling edge
   localparam logic [11:0] OFS_CLKSEL = 12'h008;  // 3 bits per cell
   localparam logic [11:0] OFS_SWRST  = 12'h00C;  // per-cell reset hold
   localparam logic [11:0] OFS_STATUS = 12'h010;  // flop and cell outputs

   // status field positions
   localparam int STS_FF_LSB  = 0;
   localparam int STS_OUT_LSB = 8;

   // reset values
   localparam logic [NUM_CELL-1:0]       RST_REGEN  = 8'h00;
   localparam logic [NUM_CELL-1:0]       RST_EDGE   = 8'h00;
   localparam logic [NUM_CELL*SEL_W-1:0] RST_CLKSEL = 24'h000000;
   localparam logic [NUM_CELL-1:0]       RST_SWRST  = 8'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CELL-1:0]             regEn;
      logic [NUM_CELL-1:0]             edgeFall;
      logic [NUM_CELL-1:0][SEL_W-1:0]  clkSel;
      logic [NUM_CELL-1:0]             swRst;
   } cior_cfg_s;

   typedef struct packed {
      logic testMode;   // cells present the update flops
      logic capture;
      logic shift;
      logic update;
      logic tdi;
   } cior_scan_s;

endpackage

// ### core/cior_top.sv
// Purpose: bank of configurable I/O cells, direct or registered
// Assumes: clock source pins are synchronous inputs sampled on ref_clk
// Notes:   apb answers with no wait state; read data is registered
//
// Operation
// - cell passes directly or through flop
// - flop reset acts at once, no edge
// - flop captures on chosen rising/falling edge
// - clock from four io or two globals
// - every cell has boundary-scan capture/update
//
// The APB register port and the register offsets were decided locally.

`timescale 1ns/1ps
`default_nettype none

module cior_top
   import cior_pkg::*;
(
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ADDR_W-1:0]      paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // cell clock sources
   input  wire logic [NUM_IO_CLK-1:0]  ioClk,
   input  wire logic [NUM_GCLK-1:0]    globalClk,
   // shared cell reset, active high
   input  wire logic                   cellRstPin,
   // input cells
   input  wire logic [NUM_IN-1:0]      padIn,
   output logic      [NUM_IN-1:0]      fabIn,
   // output cells
   input  wire logic [NUM_OUT-1:0]     fabOut,
   output logic      [NUM_OUT-1:0]     padOut,
   // boundary scan
   input  wire cior_scan_s             scanCtl,
   output logic                        scanTdo
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   cior_cfg_s           cfg_q;
   logic [SRC_X-1:0]    srcNow;
   logic [SRC_X-1:0]    srcPrev_q;
   logic [NUM_CELL-1:0] cellIn;
   logic [NUM_CELL-1:0] cellRst;
   logic [NUM_CELL-1:0] capEdge;
   logic [NUM_CELL-1:0] ff_q;
   logic [NUM_CELL-1:0] funcOut;
   logic [NUM_CELL-1:0] testVal;
   logic [NUM_CELL-1:0] cellOut;
   logic                setupPh;
   logic                wrAcc;

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   // decode in setup so read data is a flop at the access phase
   assign setupPh = psel && !penable;
   assign wrAcc   = psel && penable && pwrite;
   assign pready  = psel && penable;   // never stalls

   // read data and error, captured in setup
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (setupPh)
      begin
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         case (paddr)
            OFS_REGEN:  prdata[NUM_CELL-1:0] <= cfg_q.regEn;
            OFS_EDGE:   prdata[NUM_CELL-1:0] <= cfg_q.edgeFall;
            OFS_CLKSEL: prdata[NUM_CELL*SEL_W-1:0] <= cfg_q.clkSel;
            OFS_SWRST:  prdata[NUM_CELL-1:0] <= cfg_q.swRst;
            OFS_STATUS:
            begin
               prdata[STS_FF_LSB +: NUM_CELL]  <= ff_q;
               prdata[STS_OUT_LSB +: NUM_CELL] <= cellOut;
            end
            default:    pslverr <= 1'b1;   // unmapped address
         endcase
      end
   end

   // configuration writes; status is read-only and ignores writes
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         cfg_q.regEn    <= RST_REGEN;
         cfg_q.edgeFall <= RST_EDGE;
         cfg_q.clkSel   <= RST_CLKSEL;
         cfg_q.swRst    <= RST_SWRST;
      end
      else if (wrAcc)
      begin
         case (paddr)
            OFS_REGEN:  cfg_q.regEn    <= pwdata[NUM_CELL-1:0];
            OFS_EDGE:   cfg_q.edgeFall <= pwdata[NUM_CELL-1:0];
            OFS_CLKSEL: cfg_q.clkSel   <= pwdata[NUM_CELL*SEL_W-1:0];
            OFS_SWRST:  cfg_q.swRst    <= pwdata[NUM_CELL-1:0];
            default:    ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // clock sources
   // ------------------------------------------------------------
   // codes 6 and 7 select a constant low, so the flop never clocks
   assign srcNow = {{(SRC_X - NUM_SRC){1'b0}}, globalClk, ioClk};

   // previous sample for edge detection; it tracks the pins during
   // reset too, so a source idling high gives no false edge after it
   always_ff @(posedge ref_clk)
   begin
      srcPrev_q <= srcNow;
   end

   // cell data: inputs from pads, outputs from fabric
   assign cellIn = {fabOut, padIn};

   // ------------------------------------------------------------
   // per-cell storage and selection
   // ------------------------------------------------------------
   for (genvar i = 0; i < NUM_CELL; i++)
   begin : g_cell
      logic cur;
      logic prev;

      assign cur  = srcNow[cfg_q.clkSel[i]];
      assign prev = srcPrev_q[cfg_q.clkSel[i]];

      // edge polarity chosen per cell
      assign capEdge[i] = cfg_q.edgeFall[i] ? (prev && !cur)
                                            : (cur && !prev);

      assign cellRst[i] = cellRstPin || cfg_q.swRst[i];

      // cell flop; reset beats a coincident capture edge
      always_ff @(posedge ref_clk)
      begin
         if (!resetn)
            ff_q[i] <= 1'b0;
         else if (cellRst[i])
            ff_q[i] <= 1'b0;
         else if (capEdge[i])
            ff_q[i] <= cellIn[i];
      end

      // reset masks the flop in the same cycle, no edge needed
      assign funcOut[i] = !cfg_q.regEn[i] ? cellIn[i] :
                          (cellRst[i] ? 1'b0 : ff_q[i]);

      // scan test mode overrides the functional path
      assign cellOut[i] = scanCtl.testMode ? testVal[i]
                                           : funcOut[i];

      // ----------------------------------------------------------
      // checks
      // ----------------------------------------------------------
      property p_direct;
         @(posedge ref_clk) disable iff (!resetn)
         (!cfg_q.regEn[i] && !scanCtl.testMode) |->
            (cellOut[i] == cellIn[i]);
      endproperty
      a_direct: assert property (p_direct)
         else $error("direct cell does not follow its input");

      property p_rst_now;
         @(posedge ref_clk) disable iff (!resetn)
         (cfg_q.regEn[i] && cellRst[i]) |->
            (funcOut[i] == 1'b0) ##1 (ff_q[i] == 1'b0);
      endproperty
      a_rst_now: assert property (p_rst_now)
         else $error("cell reset did not clear output at once");

      property p_capture;
         @(posedge ref_clk) disable iff (!resetn)
         (capEdge[i] && !cellRst[i]) |=> (ff_q[i] == $past(cellIn[i]));
      endproperty
      a_capture: assert property (p_capture)
         else $error("selected edge did not capture data");

      property p_no_edge;
         @(posedge ref_clk) disable iff (!resetn)
         (!capEdge[i] && !cellRst[i]) |=> $stable(ff_q[i]);
      endproperty
      a_no_edge: assert property (p_no_edge)
         else $error("flop changed without a selected edge");

      property p_bad_src;
         @(posedge ref_clk) disable iff (!resetn)
         (cfg_q.clkSel[i] >= SEL_W'(NUM_SRC)) |-> !capEdge[i];
      endproperty
      a_bad_src: assert property (p_bad_src)
         else $error("unused clock code produced an edge");

      property p_hold_zero;
         @(posedge ref_clk) disable iff (!resetn)
         (cellRst[i] ##1 (!cellRst[i] && !capEdge[i])) |=>
            (ff_q[i] == 1'b0);
      endproperty
      a_hold_zero: assert property (p_hold_zero)
         else $error("flop left zero before a capture edge");

      if (i == 0)
      begin : g_cov
         c_rise: cover property (@(posedge ref_clk) disable iff (!resetn)
            cfg_q.regEn[i] && !cfg_q.edgeFall[i] && capEdge[i]);
         c_fall: cover property (@(posedge ref_clk) disable iff (!resetn)
            cfg_q.regEn[i] && cfg_q.edgeFall[i] && capEdge[i]);
         c_rst: cover property (@(posedge ref_clk) disable iff (!resetn)
            cfg_q.regEn[i] && ff_q[i] ##1 cellRst[i]);
      end
   end

   // ------------------------------------------------------------
   // boundary scan and pins
   // ------------------------------------------------------------
   cior_bscan u_bscan
   (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .scanCtl (scanCtl),
      .funcVal (funcOut),
      .testVal (testVal),
      .scanTdo (scanTdo)
   );

   // a complementary pad pair should come from registered cells,
   // otherwise the two legs see different combinational paths
   assign fabIn  = cellOut[NUM_IN-1:0];
   assign padOut = cellOut[NUM_CELL-1:NUM_IN];

endmodule

`default_nettype wire
